/* File: logic/test_access_top.sv */
// Array of macrocells with power-up clear and preload/observe test access.
// Assumes test mode and pin levels come from a tester, asynchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module test_access_top #(
  parameter int CELLS = test_access_pkg::CELLS
) (
  // Clock and reset
  input  wire logic                                       core_clk,
  input  wire logic                                       rst_n,
  // Fixed cell configuration
  input  wire test_access_pkg::cell_cfg_type [CELLS-1:0]  cell_cfg,
  // Array logic results
  input  wire logic [CELLS-1:0]                           sum_terms,
  input  wire logic [CELLS-1:0]                           oe_terms,
  // Tester mode pins
  input  wire logic                                       preload_pin,
  input  wire logic                                       observe_pin,
  // Cell pins, split three ways
  input  wire logic [CELLS-1:0]                           io_in,
  output logic      [CELLS-1:0]                           io_out,
  output logic      [CELLS-1:0]                           io_oe,
  // Status and state
  output logic                                            clear_done,
  output logic      [CELLS-1:0]                           state_q
);
  import test_access_pkg::*;

  logic [1:0]            pre_sync_r;
  logic [1:0]            obs_sync_r;
  logic [CELLS-1:0]      io_meta_r;
  logic [CELLS-1:0]      io_sync_r;
  logic [CLR_CNT_W-1:0]  clr_cnt_r;
  logic                  clr_busy_r;
  test_mode_type         mode_r;
  test_mode_type         mode_nxt;
  logic [CELLS-1:0]      ff_q;
  wire logic [CELLS-1:0] inv_vec;
  wire logic [CELLS-1:0] reg_vec;
  localparam int         CLEAR_BOUND = POWER_UP_CLEAR_CYC;

  ////////////////////////////////////////////////////////////////////
  // Pins from the tester pass two flops before use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_sync_r <= 2'h0;
      obs_sync_r <= 2'h0;
      io_meta_r  <= '0;
      io_sync_r  <= '0;
    end else begin
      pre_sync_r <= {pre_sync_r[0], preload_pin};
      obs_sync_r <= {obs_sync_r[0], observe_pin};
      io_meta_r  <= io_in;
      io_sync_r  <= io_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power-up clear; count rounds down so it ends inside the limit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_cnt_r  <= '0;
      clr_busy_r <= 1'b1;
    end else if (clr_busy_r) begin
      if (clr_cnt_r == CLR_CNT_W'(POWER_UP_CLEAR_CYC - 1)) begin
        clr_busy_r <= 1'b0;
      end else begin
        clr_cnt_r <= clr_cnt_r + CLR_CNT_W'(1);
      end
    end
  end

  assign clear_done = !clr_busy_r;

  ////////////////////////////////////////////////////////////////////
  // Mode select; preload wins if both pins are raised
  always_comb begin
    case ({pre_sync_r[1], obs_sync_r[1]})
      2'b10, 2'b11: mode_nxt = MODE_PRELOAD;
      2'b01:        mode_nxt = MODE_OBSERVE;
      2'b00:        mode_nxt = MODE_RUN;
      default:      mode_nxt = MODE_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_RUN;
    end else if (clr_busy_r) begin
      mode_r <= MODE_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Cells; async reset/preset come from the neighbour flip-flop
  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    localparam int NB = (i + 1) % CELLS;
    assign inv_vec[i] = cell_cfg[i].invert;
    assign reg_vec[i] = cell_cfg[i].registered;
    macro_cell u_cell (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .clr_busy  (clr_busy_r),
      .cfg       (cell_cfg[i]),
      .mode      (mode_r),
      .sum_term  (sum_terms[i]),
      .oe_term   (oe_terms[i]),
      .pin_in    (io_sync_r[i]),
      .async_rst (cell_cfg[i].ar_from_fb && ff_q[NB]),
      .async_set (cell_cfg[i].ap_from_fb && ff_q[NB]),
      .ff_q      (ff_q[i]),
      .pin_out   (io_out[i]),
      .pin_oe    (io_oe[i])
    );
  end

  assign state_q = ff_q;

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_clear_bound;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> ##[0:CLEAR_BOUND] !clr_busy_r;
  endproperty
  a_clear_bound: assert property (p_clear_bound)
    else $error("Power-up clear overran its limit");

  property p_clear_low;
    @(posedge core_clk) disable iff (!rst_n)
    clr_busy_r |=> (ff_q == '0);
  endproperty
  a_clear_low: assert property (p_clear_low)
    else $error("Flip-flop not cleared during power-up");

  // Registered cells only; combinatorial ones follow their sum term
  property p_polarity;
    @(posedge core_clk) disable iff (!rst_n)
    (clr_busy_r && $past(clr_busy_r)) |-> (((io_out ^ inv_vec) & reg_vec) == '0);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("Cleared output has wrong polarity");

  property p_preload;
    @(posedge core_clk) disable iff (!rst_n)
    (mode_r == MODE_PRELOAD && !cell_cfg[0].ar_from_fb && !cell_cfg[0].ap_from_fb
     && !clr_busy_r) |=> (ff_q[0] == $past(io_sync_r[0]));
  endproperty
  a_preload: assert property (p_preload)
    else $error("Preload did not load pin value");

  property p_async_win;
    @(posedge core_clk) disable iff (!rst_n)
    (cell_cfg[0].ar_from_fb && ff_q[1] && !clr_busy_r) |=> !ff_q[0];
  endproperty
  a_async_win: assert property (p_async_win)
    else $error("Async reset did not override");

  property p_forced_reg;
    @(posedge core_clk) disable iff (!rst_n)
    (mode_r != MODE_RUN) |-> (io_out == (ff_q ^ inv_vec));
  endproperty
  a_forced_reg: assert property (p_forced_reg)
    else $error("Output not forced registered");

  property p_comb_back;
    @(posedge core_clk) disable iff (!rst_n)
    (mode_r == MODE_RUN) |-> (((io_out ^ sum_terms ^ inv_vec) & ~reg_vec) == '0);
  endproperty
  a_comb_back: assert property (p_comb_back)
    else $error("Combinatorial output not restored");

  property p_run_clock;
    @(posedge core_clk) disable iff (!rst_n)
    (mode_r == MODE_RUN && !clr_busy_r
     && !(|{cell_cfg[0].ar_from_fb, cell_cfg[0].ap_from_fb}))
    |=> (ff_q[0] == $past(sum_terms[0]));
  endproperty
  a_run_clock: assert property (p_run_clock)
    else $error("Register did not clock normally");

  property p_zero_terms;
    @(posedge core_clk) disable iff (!rst_n)
    (mode_r == MODE_OBSERVE && !clr_busy_r
     && !cell_cfg[0].ar_from_fb && !cell_cfg[0].ap_from_fb)
    |=> (ff_q[0] == $past(ff_q[0]));
  endproperty
  a_zero_terms: assert property (p_zero_terms)
    else $error("Product terms reached register in test");

  property p_mode_held;
    @(posedge core_clk) disable iff (!rst_n)
    clr_busy_r |=> (mode_r == MODE_RUN);
  endproperty
  a_mode_held: assert property (p_mode_held)
    else $error("Test mode entered while clearing");

  property p_done_sticks;
    @(posedge core_clk) disable iff (!rst_n)
    !clr_busy_r |=> !clr_busy_r;
  endproperty
  a_done_sticks: assert property (p_done_sticks)
    else $error("Power-up clear restarted without reset");

  property p_observe_all;
    @(posedge core_clk) disable iff (!rst_n)
    (mode_r == MODE_OBSERVE) |-> (io_oe == '1);
  endproperty
  a_observe_all: assert property (p_observe_all)
    else $error("Not every buffer on in observe");

  property p_preload_wins;
    @(posedge core_clk) disable iff (!rst_n)
    (pre_sync_r[1] && !clr_busy_r) |=> (mode_r == MODE_PRELOAD);
  endproperty
  a_preload_wins: assert property (p_preload_wins)
    else $error("Preload request not taken");
endmodule : test_access_top
`default_nettype wire

/* File: logic/test_access_pkg.sv */
// Constants and carrier types for the macrocell test-access block.
// Assumes one 20 MHz core clock and an asynchronous active-low power-up reset.
//
// Contract
// - At power-up every output and buried flip-flop is cleared to low without any external reset.
// - The power-up clearing finishes within 10 microseconds of power being applied.
// - After power-up each registered output shows the cleared value through its polarity.
// - In preload mode the tester drives the pins and every flip-flop, buried too, loads them.
// - In observe mode every output buffer is forced on so register contents appear on the pins.
// - A preloaded value that asserts an asynchronous reset or preset line may overwrite the load.
// - During preload or observe every combinatorial output is switched to registered mode.
// - During that forced registered mode all product terms are driven to zero; the code zeroes only the sum terms, and the async reset/preset lines still act.
// - Once preload or observe ends a plain combinatorial output again shows its right value.
package test_access_pkg;
  localparam int  CLK_PERIOD_NS        = 50;
  localparam int  POWER_UP_CLEAR_US    = 10;
  localparam int  POWER_UP_CLEAR_CYC   = (POWER_UP_CLEAR_US * 1000) / CLK_PERIOD_NS;
  localparam int  CELLS                = 8;
  localparam int  CLR_CNT_W            = 8;
  localparam logic CLEARED_VALUE       = 1'b0;

  typedef enum logic [1:0] {MODE_RUN, MODE_PRELOAD, MODE_OBSERVE} test_mode_type;

  typedef struct packed {
    logic registered;  // Cell uses its flip-flop, else combinatorial
    logic invert;      // Output polarity
    logic buried;      // No pin drive in normal use
    logic ar_from_fb;  // Async reset driven by neighbour cell flip-flop
    logic ap_from_fb;  // Async preset driven by neighbour cell flip-flop
  } cell_cfg_type;
endpackage : test_access_pkg

/* File: logic/macro_cell.sv */
// One macrocell: flip-flop, polarity, output enable, test overrides.
// Assumes test mode and pin values arrive already synchronised.
`timescale 1ns/1ns
`default_nettype none
module macro_cell (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          clr_busy,
  // Configuration and mode
  input  wire test_access_pkg::cell_cfg_type cfg,
  input  wire test_access_pkg::test_mode_type mode,
  // Logic and pin side
  input  wire logic                          sum_term,
  input  wire logic                          oe_term,
  input  wire logic                          pin_in,
  input  wire logic                          async_rst,
  input  wire logic                          async_set,
  output logic                               ff_q,
  output logic                               pin_out,
  output logic                               pin_oe
);
  import test_access_pkg::*;

  logic test_active;
  logic sum_eff;
  logic ff_r;

  assign test_active = (mode != MODE_RUN);
  assign sum_eff     = test_active ? 1'b0 : sum_term;

  ////////////////////////////////////////////////////////////////////
  // Async reset/preset still act on top of a preload
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ff_r <= CLEARED_VALUE;
    end else if (clr_busy) begin
      ff_r <= CLEARED_VALUE;
    end else if (async_rst) begin
      ff_r <= 1'b0;
    end else if (async_set) begin
      ff_r <= 1'b1;
    end else if (mode == MODE_PRELOAD) begin
      ff_r <= pin_in;
    end else if (mode == MODE_RUN) begin
      ff_r <= sum_eff;
    end
  end

  assign ff_q = ff_r;

  ////////////////////////////////////////////////////////////////////
  // Output path; combinatorial path returns as soon as test ends
  always_comb begin
    if (test_active || cfg.registered) begin
      pin_out = ff_r ^ cfg.invert;
    end else begin
      pin_out = sum_eff ^ cfg.invert;
    end
    if (mode == MODE_OBSERVE) begin
      pin_oe = 1'b1;
    end else if (mode == MODE_PRELOAD || clr_busy) begin
      pin_oe = 1'b0;
    end else begin
      pin_oe = oe_term && !cfg.buried;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_observe_drives;
    @(posedge core_clk) disable iff (!rst_n)
    (mode == MODE_OBSERVE) |-> (pin_oe && (pin_out == (ff_r ^ cfg.invert)));
  endproperty
  a_observe_drives: assert property (p_observe_drives)
    else $error("Observe did not drive register onto pin");

  property p_preload_quiet;
    @(posedge core_clk) disable iff (!rst_n)
    (mode == MODE_PRELOAD) |-> !pin_oe;
  endproperty
  a_preload_quiet: assert property (p_preload_quiet)
    else $error("Pin driven while tester preloads");

  // No branch loads the flop in observe, so it holds unless reset/preset act
  property p_observe_holds;
    @(posedge core_clk) disable iff (!rst_n)
    (mode == MODE_OBSERVE && !clr_busy && !async_rst && !async_set) |=> $stable(ff_r);
  endproperty
  a_observe_holds: assert property (p_observe_holds)
    else $error("Register changed during observe");

  property p_run_enable;
    @(posedge core_clk) disable iff (!rst_n)
    (mode == MODE_RUN && !clr_busy) |-> (pin_oe == (oe_term && !cfg.buried));
  endproperty
  a_run_enable: assert property (p_run_enable)
    else $error("Output enable not following its control");

  property p_reset_wins;
    @(posedge core_clk) disable iff (!rst_n)
    (async_rst && !clr_busy) |=> !ff_r;
  endproperty
  a_reset_wins: assert property (p_reset_wins)
    else $error("Reset line did not clear the register");

  property p_preset_acts;
    @(posedge core_clk) disable iff (!rst_n)
    (async_set && !async_rst && !clr_busy) |=> ff_r;
  endproperty
  a_preset_acts: assert property (p_preset_acts)
    else $error("Preset line did not set the register");

  property p_comb_pin;
    @(posedge core_clk) disable iff (!rst_n)
    (mode == MODE_RUN && !cfg.registered) |-> (pin_out == (sum_term ^ cfg.invert));
  endproperty
  a_comb_pin: assert property (p_comb_pin)
    else $error("Combinatorial pin shows wrong value");
endmodule : macro_cell
`default_nettype wire

/* File: dv/tester_model.sv */
// Tester model: drives mode pins and pin levels for preload.
// Assumes the bench hands it requests at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module tester_model #(
  parameter int CELLS = 8
) (
  // Clock
  input  wire logic             core_clk,
  // Bench requests
  input  wire logic             do_preload,
  input  wire logic             do_observe,
  input  wire logic [CELLS-1:0] data,
  // Device pins
  output logic                  preload_pin,
  output logic                  observe_pin,
  output logic      [CELLS-1:0] io_in
);
  logic [2:0] hold_r;
  initial begin
    preload_pin = 1'b0;
    observe_pin = 1'b0;
    io_in = '0;
    hold_r = '0;
  end
  always @(negedge core_clk) begin
    preload_pin <= do_preload;
    observe_pin <= do_observe;
    if (do_preload) begin
      io_in  <= data;
      hold_r <= 3'h5;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1; // Hold data past the mode change
    end else begin
      io_in <= ~io_in; // Released pins show no stale level
    end
  end
endmodule : tester_model
`default_nettype wire

/* File: dv/preload_observe_powerup_reset_tb.sv */
// Bench for the test-access array: clear, run, preload, observe.
// Assumes the tester model on the pins and eight cells.
`timescale 1ns/1ns
`default_nettype none
module preload_observe_powerup_reset_tb;
  import test_access_pkg::*;
  typedef struct packed {logic [7:0] st, out, oe;} exp_type;
  localparam logic [7:0] INV = 8'h33;
  localparam logic [7:0] BUR = 8'h81;
  localparam logic [7:0] REG = 8'h0f;
  logic core_clk = 1'b0;
  logic rst_n, do_pl, do_ob, pl_pin, ob_pin, clear_done;
  logic [7:0] sum_terms, oe_terms, pdata, io_in, io_out, io_oe, state_q, s;
  cell_cfg_type [7:0] cell_cfg;
  exp_type exp_q[$];
  exp_type e;
  event chk;
  int n_fail = 0;
  int n_compared = 0;
  int n;
  logic [31:0] lfsr = 32'h5459;
  ////////////////////////////////////////////////////////////////////////
  test_access_top #(.CELLS(8)) test_access_top_i (.core_clk(core_clk),
    .rst_n(rst_n), .cell_cfg(cell_cfg), .sum_terms(sum_terms),
    .oe_terms(oe_terms), .preload_pin(pl_pin), .observe_pin(ob_pin),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .clear_done(clear_done), .state_q(state_q));
  tester_model #(.CELLS(8)) tester_model_i (.core_clk(core_clk),
    .do_preload(do_pl), .do_observe(do_ob), .data(pdata),
    .preload_pin(pl_pin), .observe_pin(ob_pin), .io_in(io_in));
  always #25 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task note(input logic [7:0] st, out, oe);
    exp_q.push_back({st, out, oe});
    -> chk;
  endtask : note
  task set_cfg(input logic [7:0] ar, ap);
    for (int i = 0; i < 8; i++) begin
      cell_cfg[i] <= {REG[i], INV[i], BUR[i], ar[i], ap[i]};
    end
  endtask : set_cfg
  task preload(input logic [7:0] v);
    do_pl <= 1'b1;
    pdata <= v;
    cyc(6);
  endtask : preload
  // Comparing process: oldest note against the settled outputs
  always @(chk) begin
    e = exp_q.pop_front();
    n_compared++;
    if (state_q !== e.st || io_out !== e.out || io_oe !== e.oe) begin
      n_fail++;
      $display("unexpected at %0t: q %h out %h oe %h", $time, state_q, io_out, io_oe);
    end
  end
  initial begin
    #(2000 * 50);
    n_fail++;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    sum_terms = '0;
    oe_terms = '1;
    do_pl = 1'b0;
    do_ob = 1'b0;
    pdata = '0;
    set_cfg(8'h00, 8'h00);
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    n = 0;
    while (clear_done !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    n_compared++;
    if (n > POWER_UP_CLEAR_CYC) begin
      n_fail++;
      $display("unexpected at %0t: clear took %0d cycles", $time, n);
    end
    note(8'h00, INV, ~BUR);
    // Drives are non-blocking so the comparer sees settled outputs
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      sum_terms <= lfsr[7:0];
      oe_terms <= lfsr[15:8];
      cyc(1);
      note(sum_terms, sum_terms ^ INV, oe_terms & ~BUR);
    end
    s = lfsr[23:16];
    preload(s);
    note(s, s ^ INV, 8'h00);
    do_pl <= 1'b0;
    do_ob <= 1'b1;
    cyc(5);
    note(s, s ^ INV, 8'hff);
    do_ob <= 1'b0;
    sum_terms <= ~s;
    cyc(5);
    note(~s, s ^ INV ^ 8'hff, oe_terms & ~BUR);
    // Cell 0 reset by cell 1, cell 2 preset by cell 3; both pins up
    set_cfg(8'h01, 8'h04);
    do_ob <= 1'b1;
    preload(8'h0b);
    note(8'h0e, 8'h0e ^ INV, 8'h00);
    do_pl <= 1'b0;
    do_ob <= 1'b0;
    cyc(5);
    final_report;
  end
endmodule : preload_observe_powerup_reset_tb
`default_nettype wire
